// >>> verilog/tprc_timer_io.sv
// Timer pin routing and capture event control, register front end
// Assumes a same-clock register master and a counter core beside it
//
// Function
// R1: Two-bit field picks one of four pin locations
// R2: Bits 8-10 connect complementary outputs, reset off
// R3: Bits 0-2 connect channel pin paths, reset off
// R4: Software writes zero to unused routing bits
// R5: Event control zero: event on every capture
// R6: Event control one: event every second capture
// R7: Control two with both edges: rising only
// R8: Control three with both edges: falling only
// R9: Edge select drives capture and external clock; with none selected, the raw level feeds external clock
// R10: Edge codes: rise, fall, both, none
// R11: Alternate toggle cleared at reset, second fires
//
// Local design decision: the strobed register port.

`timescale 1ns/1ps

module tprc_timer_io (
  input  wire logic            core_clk,
  input  wire logic            nrst,
  input  wire logic [7:0]      bus_addr,
  input  wire logic [31:0]     bus_wdata,
  input  wire logic            bus_wr,
  input  wire logic            bus_rd,
  output logic      [31:0]     bus_rdata,
  input  wire logic [2:0]      cmp_out,
  input  wire logic [2:0]      cmp_oe,
  input  wire logic [2:0]      dti_out,
  output logic      [2:0]      capture_pulse,
  output logic      [2:0]      ext_clk_det,
  output logic      [2:0]      peripheral_event_bus,
  output logic      [2:0]      dma_req,
  input  wire logic [2:0]      dma_ack,
  output logic                 irq,
  input  wire logic [3:0][2:0] cc_pin_in,
  output logic      [3:0][2:0] cc_pin_out,
  output logic      [3:0][2:0] cc_pin_oe_n,
  output logic      [3:0][2:0] dti_pin_out,
  output logic      [3:0][2:0] dti_pin_oe_n
);

  typedef struct packed {
    tprc_pkg::tprc_route_s             route;
    tprc_pkg::tprc_chctrl_s [2:0]      ctrl;
    logic [2:0]                        status;
    logic [2:0]                        mask;
    logic [2:0]                        dma;
    logic [31:0]                       rdata;
  } tprc_top_s;

  localparam tprc_top_s ST_RST = '{
    route:  '{location: tprc_pkg::LOC_RST,
              comp_pen: tprc_pkg::COMP_PEN_RST,
              pen:      tprc_pkg::PEN_RST},
    ctrl:   '{default: '{capture_event_control: tprc_pkg::EV_EACH_CAPTURE,
                         capture_edge_select:   tprc_pkg::EDGE_RISE}},
    status: tprc_pkg::IRQ_RST,
    mask:   tprc_pkg::IRQ_RST,
    dma:    3'h0,
    rdata:  32'h00000000
  };

  tprc_top_s           st;
  tprc_top_s           next_st;
  tprc_pkg::tprc_bus_s bus;
  logic [2:0]          cap_in;
  logic [2:0]          ev;
  logic [2:0]          ch_sel;

  assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  // ---------------------------------------------------------------------
  // Pin routing
  // ---------------------------------------------------------------------
  tprc_pin_router u_router (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .route        (st.route),
    .cmp_out      (cmp_out),
    .cmp_oe       (cmp_oe),
    .dti_out      (dti_out),
    .cc_pin_in    (cc_pin_in),
    .cc_pin_out   (cc_pin_out),
    .cc_pin_oe_n  (cc_pin_oe_n),
    .dti_pin_out  (dti_pin_out),
    .dti_pin_oe_n (dti_pin_oe_n),
    .cap_in       (cap_in)
  );

  // ---------------------------------------------------------------------
  // Per-channel edge detect and event qualify
  // ---------------------------------------------------------------------
  for (genvar c = 0; c < tprc_pkg::NUM_CH; c++)
  begin : g_ch
    tprc_capture_event u_cev (
      .core_clk    (core_clk),
      .nrst        (nrst),
      .sig         (cap_in[c]),
      .ctrl        (st.ctrl[c]),
      .capture     (capture_pulse[c]),
      .det_out     (ext_clk_det[c]),
      .event_pulse (ev[c])
    );
    assign ch_sel[c] = (bus.addr == 8'(tprc_pkg::CH_CTRL_OFS +
                        8'(c) * tprc_pkg::CH_CTRL_STRIDE));
  end

  // ---------------------------------------------------------------------
  // Register file and event bookkeeping
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_st = st;

    if (bus.wr)
    begin
      if (bus.addr == tprc_pkg::PIN_ROUTING_OFS)
      begin
        next_st.route.location = bus.wdata[tprc_pkg::LOC_LSB +: 2]; // R1
        next_st.route.comp_pen =
          bus.wdata[tprc_pkg::COMP_PEN_LSB +: 3]; // R2
        next_st.route.pen      = bus.wdata[tprc_pkg::PEN_LSB +: 3]; // R3
      end
      for (int c = 0; c < tprc_pkg::NUM_CH; c++)
      begin
        if (ch_sel[c])
        begin
          next_st.ctrl[c].capture_event_control = tprc_pkg::tprc_evctrl_e'(
            bus.wdata[tprc_pkg::EV_CTRL_LSB +: 2]); // R5
          next_st.ctrl[c].capture_edge_select = tprc_pkg::tprc_edge_e'(
            bus.wdata[tprc_pkg::EDGE_SEL_LSB +: 2]); // R9
        end
      end
      if (bus.addr == tprc_pkg::IRQ_MASK_OFS)
        next_st.mask = bus.wdata[2:0];
    end

    // Event wins over a same-cycle write-one clear
    next_st.status = st.status;
    if (bus.wr && bus.addr == tprc_pkg::IRQ_STATUS_OFS)
      next_st.status = st.status & ~bus.wdata[2:0];
    next_st.status = next_st.status | ev; // R5

    // Request held until acknowledged, new event wins
    next_st.dma = (st.dma & ~dma_ack) | ev; // R5

    next_st.rdata = 32'h00000000;
    if (bus.rd)
    begin
      if (bus.addr == tprc_pkg::PIN_ROUTING_OFS)
      begin
        next_st.rdata[tprc_pkg::LOC_LSB +: 2]      = st.route.location;
        next_st.rdata[tprc_pkg::COMP_PEN_LSB +: 3] = st.route.comp_pen;
        next_st.rdata[tprc_pkg::PEN_LSB +: 3]      = st.route.pen;
      end
      for (int c = 0; c < tprc_pkg::NUM_CH; c++)
      begin
        if (ch_sel[c])
        begin
          next_st.rdata[tprc_pkg::EV_CTRL_LSB +: 2] =
            st.ctrl[c].capture_event_control;
          next_st.rdata[tprc_pkg::EDGE_SEL_LSB +: 2] =
            st.ctrl[c].capture_edge_select;
        end
      end
      if (bus.addr == tprc_pkg::IRQ_STATUS_OFS)
        next_st.rdata[2:0] = st.status;
      if (bus.addr == tprc_pkg::IRQ_MASK_OFS)
        next_st.rdata[2:0] = st.mask;
      if (bus.addr == tprc_pkg::LEVEL_OFS)
      begin
        next_st.rdata[2:0]                        = cap_in;
        next_st.rdata[tprc_pkg::LVL_DMA_LSB +: 3] = st.dma;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      st <= ST_RST; // R1 R2 R3
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign bus_rdata            = st.rdata;
  assign peripheral_event_bus = ev;
  assign dma_req              = st.dma;
  assign irq                  = |(st.status & st.mask);

endmodule : tprc_timer_io

// >>> verilog/tprc_pkg.sv
// Shared constants and carrier types for timer pin routing and capture events
// Assumes a single 50 MHz core clock and a plain strobe register port

package tprc_pkg;

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int NUM_CH  = 3;
  localparam int NUM_LOC = 4;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] PIN_ROUTING_OFS = 8'h28;
  localparam logic [7:0] CH_CTRL_OFS     = 8'h30;
  localparam logic [7:0] CH_CTRL_STRIDE  = 8'h10;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'hF0;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'hF4;
  localparam logic [7:0] LEVEL_OFS       = 8'hF8;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int LOC_LSB       = 16;
  localparam int COMP_PEN_LSB  = 8;
  localparam int PEN_LSB       = 0;
  localparam int EV_CTRL_LSB   = 26;
  localparam int EDGE_SEL_LSB  = 24;
  localparam int LVL_DMA_LSB   = 8;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [1:0] LOC_RST      = 2'h0;
  localparam logic [2:0] PEN_RST      = 3'h0;
  localparam logic [2:0] COMP_PEN_RST = 3'h0;
  localparam logic [2:0] IRQ_RST      = 3'h0;

  // ---------------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_NONE = 2'b11
  } tprc_edge_e;

  typedef enum logic [1:0] {
    EV_EACH_CAPTURE = 2'b00,
    EV_ALT_CAPTURE  = 2'b01,
    EV_RISE_ONLY    = 2'b10,
    EV_FALL_ONLY    = 2'b11
  } tprc_evctrl_e;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] location;
    logic [2:0] comp_pen;
    logic [2:0] pen;
  } tprc_route_s;

  typedef struct packed {
    tprc_evctrl_e capture_event_control;
    tprc_edge_e   capture_edge_select;
  } tprc_chctrl_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tprc_bus_s;

endpackage : tprc_pkg

// >>> verilog/tprc_capture_event.sv
// One channel edge detector and capture event qualifier
// Assumes its input level is already synchronised to core_clk

`timescale 1ns/1ps

module tprc_capture_event (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   sig,
  input  wire tprc_pkg::tprc_chctrl_s ctrl,
  output logic                        capture,
  output logic                        det_out,
  output logic                        event_pulse
);

  typedef struct packed {
    logic prev;
    logic toggle;
    logic event_q;
  } tprc_cev_s;

  tprc_cev_s st;
  tprc_cev_s next_st;
  logic      rise;
  logic      fall;
  logic      qualify;

  // ---------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------
  always_comb
  begin
    rise    = sig & ~st.prev;
    fall    = ~sig & st.prev;
    capture = 1'b0;
    det_out = 1'b0;
    case (ctrl.capture_edge_select)
      tprc_pkg::EDGE_RISE:
      begin
        capture = rise; // R10
      end
      tprc_pkg::EDGE_FALL:
      begin
        capture = fall; // R10
      end
      tprc_pkg::EDGE_BOTH:
      begin
        capture = rise | fall; // R10
      end
      tprc_pkg::EDGE_NONE:
      begin
        capture = 1'b0;
      end
      default:
      begin
        capture = 1'b0;
      end
    endcase
    // Same detector output feeds capture and external clock, except with no edge selected the raw level feeds external clock
    det_out = (ctrl.capture_edge_select == tprc_pkg::EDGE_NONE) ?
              sig : capture; // R9 R10

    qualify = 1'b0;
    case (ctrl.capture_event_control)
      tprc_pkg::EV_EACH_CAPTURE:
      begin
        qualify = capture; // R5
      end
      tprc_pkg::EV_ALT_CAPTURE:
      begin
        qualify = capture & st.toggle; // R6 R11
      end
      tprc_pkg::EV_RISE_ONLY:
      begin
        // Plain capture unless both edges are armed
        qualify = (ctrl.capture_edge_select == tprc_pkg::EDGE_BOTH) ?
                  (capture & rise) : capture; // R7
      end
      tprc_pkg::EV_FALL_ONLY:
      begin
        qualify = (ctrl.capture_edge_select == tprc_pkg::EDGE_BOTH) ?
                  (capture & fall) : capture; // R8
      end
      default:
      begin
        qualify = 1'b0;
      end
    endcase

    next_st         = st;
    next_st.prev    = sig;
    next_st.toggle  = (ctrl.capture_event_control ==
                       tprc_pkg::EV_ALT_CAPTURE && capture) ?
                      ~st.toggle : st.toggle; // R11
    next_st.event_q = qualify;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      st <= '0; // R11
    else
      st <= next_st;
  end

  assign event_pulse = st.event_q;

endmodule : tprc_capture_event

// >>> verilog/tprc_pin_router.sv
// Pin location mux for channel and complementary outputs, input sync
// Assumes pin inputs are asynchronous to core_clk

`timescale 1ns/1ps

module tprc_pin_router (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire tprc_pkg::tprc_route_s route,
  input  wire logic [2:0]            cmp_out,
  input  wire logic [2:0]            cmp_oe,
  input  wire logic [2:0]            dti_out,
  input  wire logic [3:0][2:0]       cc_pin_in,
  output logic      [3:0][2:0]       cc_pin_out,
  output logic      [3:0][2:0]       cc_pin_oe_n,
  output logic      [3:0][2:0]       dti_pin_out,
  output logic      [3:0][2:0]       dti_pin_oe_n,
  output logic      [2:0]            cap_in
);

  typedef struct packed {
    logic [3:0][2:0] sync1;
    logic [3:0][2:0] sync2;
    logic [3:0][2:0] pin_out;
    logic [3:0][2:0] pin_oe_n;
    logic [3:0][2:0] dti_out;
    logic [3:0][2:0] dti_oe_n;
    logic [2:0]      cap;
  } tprc_rtr_s;

  tprc_rtr_s st;
  tprc_rtr_s next_st;

  // ---------------------------------------------------------------------
  // Location select
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.sync1 = cc_pin_in;
    next_st.sync2 = st.sync1;
    for (int l = 0; l < tprc_pkg::NUM_LOC; l++)
    begin
      for (int c = 0; c < tprc_pkg::NUM_CH; c++)
      begin
        next_st.pin_out[l][c]  = cmp_out[c];
        next_st.pin_oe_n[l][c] = ~(route.pen[c] && cmp_oe[c] &&
                                   route.location == 2'(l)); // R1 R3
        next_st.dti_out[l][c]  = dti_out[c];
        next_st.dti_oe_n[l][c] = ~(route.comp_pen[c] &&
                                   route.location == 2'(l)); // R1 R2
      end
    end
    for (int c = 0; c < tprc_pkg::NUM_CH; c++)
    begin
      next_st.cap[c] = route.pen[c] & st.sync2[route.location][c]; // R3
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      st          <= '0;
      st.pin_oe_n <= '1;
      st.dti_oe_n <= '1;
    end
    else
      st <= next_st;
  end

  assign cc_pin_out   = st.pin_out;
  assign cc_pin_oe_n  = st.pin_oe_n;
  assign dti_pin_out  = st.dti_out;
  assign dti_pin_oe_n = st.dti_oe_n;
  assign cap_in       = st.cap;

endmodule : tprc_pin_router

// >>> tb/tprc_timer_io_asserts.sv
// Checker for timer pin routing and capture events
// Sees only top ports; shadows register writes itself
`timescale 1ns/1ps
module tprc_timer_io_asserts (
  input wire logic            core_clk,
  input wire logic            nrst,
  input wire logic [7:0]      bus_addr,
  input wire logic [31:0]     bus_wdata,
  input wire logic            bus_wr,
  input wire logic            bus_rd,
  input wire logic [31:0]     bus_rdata,
  input wire logic [2:0]      cmp_out,
  input wire logic [2:0]      cmp_oe,
  input wire logic [2:0]      dti_out,
  input wire logic [2:0]      capture_pulse,
  input wire logic [2:0]      ext_clk_det,
  input wire logic [2:0]      peripheral_event_bus,
  input wire logic [2:0]      dma_req,
  input wire logic            irq,
  input wire logic [3:0][2:0] cc_pin_out,
  input wire logic [3:0][2:0] cc_pin_oe_n,
  input wire logic [3:0][2:0] dti_pin_out,
  input wire logic [3:0][2:0] dti_pin_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [31:0]     rt;
  logic [2:0][3:0] cc;
  // Shadow of routing and channel control
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rt <= '0;
      cc <= '0;
    end
    else if (bus_wr)
    begin
      if (bus_addr == tprc_pkg::PIN_ROUTING_OFS)
        rt <= bus_wdata;
      for (int i = 0; i < 3; i++)
        if (bus_addr == tprc_pkg::CH_CTRL_OFS + 8'(16 * i))
          cc[i] <= bus_wdata[27:24];
    end
  end
  property p_oe(int l, int c);
    $past(nrst) |-> cc_pin_oe_n[l][c] == !($past(rt[17:16]) == l
      && $past(rt[c]) && $past(cmp_oe[c]));
  endproperty
  property p_dti(int l, int c);
    $past(nrst) |-> dti_pin_oe_n[l][c] ==
      !($past(rt[17:16]) == l && $past(rt[8 + c]));
  endproperty
  property p_copy(int l, int c);
    $past(nrst) |-> cc_pin_out[l][c] == $past(cmp_out[c])
      && dti_pin_out[l][c] == $past(dti_out[c]);
  endproperty
  property p_rsv;
    bus_rd && bus_addr == tprc_pkg::PIN_ROUTING_OFS
      |=> bus_rdata == (rt & 32'h0003_0707);
  endproperty
  property p_each(int c);
    capture_pulse[c] && cc[c][3:2] == 2'h0 |=> peripheral_event_bus[c];
  endproperty
  property p_cause(int c);
    peripheral_event_bus[c] |-> $past(capture_pulse[c]) ##1 dma_req[c];
  endproperty
  property p_none(int c);
    cc[c][1:0] == 2'h3 && $past(cc[c][1:0]) == 2'h3 |-> !capture_pulse[c];
  endproperty
  property p_det(int c);
    cc[c][1:0] != 2'h3 |-> ext_clk_det[c] == capture_pulse[c];
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("routing readback mismatch");
  for (genvar c = 0; c < 3; c++)
  begin : g_ch
    for (genvar l = 0; l < 4; l++)
    begin : g_loc
      a_oe: assert property (p_oe(l, c))
        else $error("pin enable mismatch");
      a_dti: assert property (p_dti(l, c))
        else $error("complement enable mismatch");
      a_copy: assert property (p_copy(l, c))
        else $error("pin output copy mismatch");
    end
    a_each: assert property (p_each(c))
      else $error("capture without event");
    a_cause: assert property (p_cause(c))
      else $error("event without capture or request");
    a_none: assert property (p_none(c))
      else $error("capture while detection off");
    a_det: assert property (p_det(c))
      else $error("detector output mismatch");
  end
  c_ev: cover property (peripheral_event_bus[1]);
  c_irq: cover property ($rose(irq));
  c_dma: cover property ($fell(dma_req[0]));
endmodule : tprc_timer_io_asserts
bind tprc_timer_io tprc_timer_io_asserts u_chk (
  .core_clk(core_clk), .nrst(nrst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .cmp_out(cmp_out), .cmp_oe(cmp_oe),
  .dti_out(dti_out), .capture_pulse(capture_pulse),
  .ext_clk_det(ext_clk_det), .peripheral_event_bus(peripheral_event_bus),
  .dma_req(dma_req), .irq(irq), .cc_pin_out(cc_pin_out),
  .cc_pin_oe_n(cc_pin_oe_n), .dti_pin_out(dti_pin_out),
  .dti_pin_oe_n(dti_pin_oe_n));

// >>> tb/tprc_pins_model.sv
// External pins: one source per channel at a chosen location
// Other undriven locations toggle every cycle
`timescale 1ns/1ps
module tprc_pins_model (
  input  wire logic            core_clk,
  input  wire logic            nrst,
  input  wire logic [1:0]      src_loc,
  input  wire logic [2:0]      src_lvl,
  input  wire logic [3:0][2:0] cc_pin_out,
  input  wire logic [3:0][2:0] cc_pin_oe_n,
  output logic      [3:0][2:0] cc_pin_in
);
  logic noise;
  always_ff @(posedge core_clk)
    noise <= nrst ? !noise : 1'b0;
  // Driven pin wins over the external source
  always_comb
    for (int l = 0; l < 4; l++)
      for (int c = 0; c < 3; c++)
        if (!cc_pin_oe_n[l][c])
          cc_pin_in[l][c] = cc_pin_out[l][c];
        else if (l == src_loc)
          cc_pin_in[l][c] = src_lvl[c];
        else
          cc_pin_in[l][c] = noise ^ (c == 1);
endmodule : tprc_pins_model

// >>> tb/test_tprc_timer_io.sv
// Self-checking bench for timer pin routing and capture events
// Pins come from the partner model; checker is bound in
`timescale 1ns/1ps
module test_tprc_timer_io;
  logic core_clk = 1'b0, nrst = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, irq;
  logic [7:0] bus_addr = '0;
  logic [31:0] bus_wdata = '0, bus_rdata;
  logic [2:0] cmp_out = '0, cmp_oe = '0, dti_out = '0, dma_ack = '0;
  logic [2:0] capture_pulse, ext_clk_det, peripheral_event_bus, dma_req;
  logic [2:0] src_lvl = '0;
  logic [1:0] src_loc = '0;
  logic [3:0][2:0] cc_pin_in, cc_pin_out, cc_pin_oe_n;
  logic [3:0][2:0] dti_pin_out, dti_pin_oe_n;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  int caps[3], evs[3];
  tprc_timer_io u_dut (.core_clk(core_clk), .nrst(nrst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cmp_out(cmp_out),
    .cmp_oe(cmp_oe), .dti_out(dti_out), .capture_pulse(capture_pulse),
    .ext_clk_det(ext_clk_det), .peripheral_event_bus(peripheral_event_bus),
    .dma_req(dma_req), .dma_ack(dma_ack), .irq(irq),
    .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out),
    .cc_pin_oe_n(cc_pin_oe_n), .dti_pin_out(dti_pin_out),
    .dti_pin_oe_n(dti_pin_oe_n));
  tprc_pins_model u_pins (.core_clk(core_clk), .nrst(nrst),
    .src_loc(src_loc), .src_lvl(src_lvl), .cc_pin_out(cc_pin_out),
    .cc_pin_oe_n(cc_pin_oe_n), .cc_pin_in(cc_pin_in));
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // Pulse counters and hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    for (int c = 0; c < 3; c++)
    begin
      caps[c] += int'(capture_pulse[c] === 1'b1);
      evs[c] += int'(peripheral_event_bus[c] === 1'b1);
    end
    if (cyc == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask : rc
  task automatic pin(input int c, input logic v);
    @(posedge core_clk);
    src_lvl[c] <= v;
    repeat (8) @(posedge core_clk);
  endtask : pin
  function automatic logic [7:0] ctl(input int c);
    return tprc_pkg::CH_CTRL_OFS + 8'(16 * c);
  endfunction : ctl
  task automatic t_reset;
    rc(tprc_pkg::PIN_ROUTING_OFS, 32'h0);
    for (int c = 0; c < 3; c++)
      rc(ctl(c), 32'h0);
    chk({20'h0, cc_pin_oe_n}, 32'h0000_0FFF);
    chk({20'h0, dti_pin_oe_n}, 32'h0000_0FFF);
  endtask : t_reset
  task automatic t_route;
    logic [11:0] e;
    @(posedge core_clk);
    cmp_oe <= 3'h7;
    cmp_out <= 3'h5;
    dti_out <= 3'h3;
    for (int l = 0; l < 4; l++)
    begin
      wr(tprc_pkg::PIN_ROUTING_OFS, 32'h0000_0605 | (32'(l) << 16));
      rc(tprc_pkg::PIN_ROUTING_OFS, 32'h0000_0605 | (32'(l) << 16));
      e = 12'hFFF;
      e[3 * l +: 3] = 3'h2;
      chk({20'h0, cc_pin_oe_n}, {20'h0, e});
      e[3 * l +: 3] = 3'h1;
      chk({20'h0, dti_pin_oe_n}, {20'h0, e});
      chk({29'h0, cc_pin_out[l]}, 32'h5);
      chk({29'h0, dti_pin_out[l]}, 32'h3);
    end
    wr(8'h14, 32'hFFFF_FFFF);
    rc(8'h14, 32'h0);
    rc(tprc_pkg::PIN_ROUTING_OFS, 32'h0003_0605);
    @(posedge core_clk);
    cmp_oe <= 3'h0;
  endtask : t_route
  task automatic t_edges;
    int n, m;
    logic [3:0] rise = 4'b0101;
    int tot[4] = '{1, 1, 2, 0};
    src_loc <= 2'h1;
    wr(tprc_pkg::PIN_ROUTING_OFS, 32'h0001_0006);
    n = caps[0];
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk(caps[0] - n, 32'h0);
    wr(tprc_pkg::PIN_ROUTING_OFS, 32'h0001_0007);
    repeat (8) @(posedge core_clk);
    for (int e = 0; e < 4; e++)
    begin
      wr(ctl(0), 32'(e) << 24);
      n = caps[0];
      m = evs[0];
      pin(0, 1'b1);
      chk(caps[0] - n, 32'(rise[e]));
      if (e == 3)
        chk({31'h0, ext_clk_det[0]}, 32'h1);
      pin(0, 1'b0);
      chk(caps[0] - n, tot[e]);
      chk(evs[0] - m, tot[e]);
    end
  endtask : t_edges
  task automatic t_alt;
    int m;
    wr(ctl(1), 32'h0600_0000);
    m = evs[1];
    pin(1, 1'b1);
    chk(evs[1] - m, 32'h0);
    pin(1, 1'b0);
    chk(evs[1] - m, 32'h1);
    pin(1, 1'b1);
    pin(1, 1'b0);
    chk(evs[1] - m, 32'h2);
  endtask : t_alt
  task automatic t_rf;
    int m;
    for (int e = 2; e < 4; e++)
    begin
      wr(ctl(2), 32'h0200_0000 | (32'(e) << 26));
      m = evs[2];
      pin(2, 1'b1);
      chk(evs[2] - m, 32'(e == 2));
      pin(2, 1'b0);
      chk(evs[2] - m, 32'h1);
    end
  endtask : t_rf
  task automatic t_irq;
    rc(tprc_pkg::IRQ_STATUS_OFS, 32'h7);
    rc(tprc_pkg::LEVEL_OFS, 32'h0000_0700);
    chk({31'h0, irq}, 32'h0);
    wr(tprc_pkg::IRQ_MASK_OFS, 32'h1);
    #1 chk({31'h0, irq}, 32'h1);
    wr(tprc_pkg::IRQ_STATUS_OFS, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    rc(tprc_pkg::IRQ_STATUS_OFS, 32'h6);
    @(posedge core_clk);
    dma_ack <= 3'h1;
    @(posedge core_clk);
    dma_ack <= 3'h0;
    @(posedge core_clk);
    #1 chk({29'h0, dma_req}, 32'h6);
  endtask : t_irq
  initial
  begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_route();
    t_edges();
    t_alt();
    t_rf();
    t_irq();
    tally_and_finish();
  end
endmodule : test_tprc_timer_io
